// ===== include/sram_host_pkg.sv
// Shared types and timing constants for the asynchronous SRAM host controller
package sram_host_pkg;

    // ======================================================================
    // Widths
    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;

    // ======================================================================
    // Timing in ns, and clock cycle counts at 20 MHz
    localparam int CLK_PERIOD_NS              = 50;
    localparam int READ_CYCLE_NS              = 45;
    localparam int ADDRESS_ACCESS_TIME_NS     = 45;
    localparam int OUTPUT_STROBE_ACCESS_NS    = 22;
    localparam int WRITE_CYCLE_NS             = 45;
    localparam int WRITE_PULSE_NS             = 35;
    localparam int WRITE_DATA_LEAD_TIME_NS    = 25;
    localparam int WRITE_LOW_FLOAT_TIME_NS    = 18;
    localparam int DESELECT_TO_RETENTION_NS   = 0;
    localparam int POST_RETENTION_RECOVERY_NS = 45;

    function automatic int ceil_cycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // Write pulse covers pulse width, and data lead plus float time
    localparam int WR_PULSE_NS_MAX =
        (WRITE_PULSE_NS > WRITE_DATA_LEAD_TIME_NS + WRITE_LOW_FLOAT_TIME_NS) ?
        WRITE_PULSE_NS : WRITE_DATA_LEAD_TIME_NS + WRITE_LOW_FLOAT_TIME_NS;
    localparam int RD_ACCESS_NS_MAX =
        (ADDRESS_ACCESS_TIME_NS > READ_CYCLE_NS) ?
        ADDRESS_ACCESS_TIME_NS : READ_CYCLE_NS;

    localparam logic [3:0] WR_PULSE_CYC  = 4'(ceil_cycles(WR_PULSE_NS_MAX));
    localparam logic [3:0] RD_ACCESS_CYC = 4'(ceil_cycles(RD_ACCESS_NS_MAX));
    localparam logic [3:0] RECOVERY_CYC  =
        4'(ceil_cycles(POST_RETENTION_RECOVERY_NS));
    localparam logic [3:0] CNT_ZERO      = 4'h0;

    // ======================================================================
    // Carriers
    typedef struct packed {
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [1:0]        lane_en;   // bit1 upper, bit0 lower; active high
    } req_s;

    typedef struct packed {
        logic              select_low_active;
        logic              select_high_active;
        logic              write_strobe_n;
        logic              output_strobe_n;
        logic              upper_lane_enable_n;
        logic              lower_lane_enable_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq_out;
        logic              dq_oe;
    } pins_s;

    typedef enum logic [2:0] {
        ST_IDLE, ST_RD, ST_WR, ST_WR_END, ST_RETAIN, ST_RECOVER
    } state_e;

    localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 18'h00000;

endpackage

// ===== src/sync2.sv
// Two-flop synchroniser for a bus of asynchronous inputs
`timescale 1ns/100ps
module sync2 #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_ff <= '0;
            q       <= '0;
        end else begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end
endmodule

// ===== src/sram_host.sv
// Host controller driving an asynchronous 16-bit byte-lane static RAM
//
// Summary of operation
// - Write starts with strobe and both selects
// - Data valid 25 ns before write end
// - Data may change at write end
// - Address stable 35 ns before write end
// - Address valid at write start
// - Lane enables low 35 ns before end
// - Write pulse at least 25 plus 18 ns
// - Address valid before select falls; here both are set on the same clock edge
// - Deselect before entering retention
`timescale 1ns/100ps
module sram_host
    import sram_host_pkg::*;
(
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    // User request
    input  wire logic                        req_valid,
    input  wire sram_host_pkg::req_s         req,
    output logic                             req_ready,
    output logic                             rd_valid,
    output logic [sram_host_pkg::DATA_W-1:0] rd_data,
    // Retention control
    input  wire logic                        retain_req,
    output logic                             retain_ok,
    // Memory pins
    output sram_host_pkg::pins_s             pins,
    input  wire logic [sram_host_pkg::DATA_W-1:0] dq_in
);
    import sram_host_pkg::*;

    typedef struct packed {
        state_e            st;
        logic [3:0]        cnt;
        pins_s             p;
        logic              ready;
        logic              rvalid;
        logic [DATA_W-1:0] rdata;
        logic              retain;
    } state_s;

    state_s            cur_ff;
    state_s            nxt_cur;
    logic [DATA_W-1:0] dq_sync;

    // All checks below sample on the one clock, quiet during reset
    default clocking chk_cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sync2 #(.W(DATA_W)) u_dq_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (dq_in),
        .q     (dq_sync)
    );

    function automatic pins_s idle_pins(input pins_s p);
        pins_s r;
        r = p;
        r.select_low_active   = 1'b1;
        r.select_high_active  = 1'b0;
        r.write_strobe_n      = 1'b1;
        r.output_strobe_n     = 1'b1;
        r.upper_lane_enable_n = 1'b1;
        r.lower_lane_enable_n = 1'b1;
        r.dq_oe               = 1'b0;
        return r;
    endfunction

    // ======================================================================
    // Sequencer
    always_comb begin
        nxt_cur        = cur_ff;
        nxt_cur.rvalid = 1'b0;
        if (cur_ff.cnt != CNT_ZERO) begin
            nxt_cur.cnt = cur_ff.cnt - 4'h1;
        end
        unique case (cur_ff.st)
            ST_IDLE: begin
                if (retain_req) begin
                    nxt_cur.p      = idle_pins(cur_ff.p);
                    nxt_cur.st     = ST_RETAIN;
                    nxt_cur.ready  = 1'b0;
                    nxt_cur.retain = 1'b1;
                end else if (req_valid && cur_ff.ready) begin
                    nxt_cur.ready                 = 1'b0;
                    nxt_cur.p.addr                = req.addr;
                    nxt_cur.p.select_low_active   = 1'b0;
                    nxt_cur.p.select_high_active  = 1'b1;
                    nxt_cur.p.upper_lane_enable_n = ~req.lane_en[1];
                    nxt_cur.p.lower_lane_enable_n = ~req.lane_en[0];
                    if (req.wr) begin
                        nxt_cur.p.write_strobe_n = 1'b0;
                        nxt_cur.p.dq_out         = req.wdata;
                        nxt_cur.p.dq_oe          = 1'b1;
                        nxt_cur.cnt              = WR_PULSE_CYC - 4'h1;
                        nxt_cur.st               = ST_WR;
                    end else begin
                        nxt_cur.p.output_strobe_n = 1'b0;
                        nxt_cur.cnt = RD_ACCESS_CYC + 4'h1;
                        nxt_cur.st  = ST_RD;
                    end
                end
            end
            ST_WR: begin
                if (cur_ff.cnt == CNT_ZERO) begin
                    // held through full pulse, strobe ends
                    nxt_cur.p.write_strobe_n = 1'b1;
                    nxt_cur.st               = ST_WR_END;
                end
            end
            ST_WR_END: begin
                nxt_cur.p   = idle_pins(cur_ff.p);
                nxt_cur.st  = ST_IDLE;
                nxt_cur.ready = 1'b1;
            end
            ST_RD: begin
                // Extra count covers the synchroniser delay
                if (cur_ff.cnt == CNT_ZERO) begin
                    nxt_cur.rdata  = dq_sync;
                    nxt_cur.rvalid = 1'b1;
                    nxt_cur.p      = idle_pins(cur_ff.p);
                    nxt_cur.st     = ST_IDLE;
                    nxt_cur.ready  = 1'b1;
                end
            end
            ST_RETAIN: begin
                if (!retain_req) begin
                    // wait one cycle time after retention
                    nxt_cur.retain = 1'b0;
                    nxt_cur.cnt    = RECOVERY_CYC;
                    nxt_cur.st     = ST_RECOVER;
                end
            end
            ST_RECOVER: begin
                if (cur_ff.cnt == CNT_ZERO) begin
                    nxt_cur.st    = ST_IDLE;
                    nxt_cur.ready = 1'b1;
                end
            end
            // Unused state codes fall back to a safe idle bus
            default: begin
                nxt_cur.p     = idle_pins(cur_ff.p);
                nxt_cur.st    = ST_IDLE;
                nxt_cur.ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cur_ff        <= '0;
            cur_ff.st     <= ST_IDLE;
            cur_ff.ready  <= 1'b1;
            cur_ff.p      <= idle_pins('0);
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign pins      = cur_ff.p;
    assign req_ready = cur_ff.ready;
    assign rd_valid  = cur_ff.rvalid;
    assign rd_data   = cur_ff.rdata;
    assign retain_ok = cur_ff.retain;

    // ======================================================================
    // Checks
    sequence s_write_start;
        $fell(pins.write_strobe_n);
    endsequence

    // Strobe is the terminating edge; selects still held behind it
    sequence s_write_end;
        $rose(pins.write_strobe_n) && !pins.select_low_active
            && pins.select_high_active;
    endsequence

    a_write_qualified: assert property (
        s_write_start |-> !pins.select_low_active && pins.select_high_active
    ) else $error("write started without both selects");

    // One 50 ns cycle already covers the 43 ns minimum pulse
    a_write_pulse_len: assert property (
        s_write_start |=> s_write_end
    ) else $error("write pulse length wrong");

    a_wdata_stable: assert property (
        s_write_start |=> $stable(pins.dq_out) && pins.dq_oe
    ) else $error("write data moved during pulse");

    a_addr_stable: assert property (
        $rose(pins.write_strobe_n) |-> $stable(pins.addr)
    ) else $error("address moved during write");

    a_lane_hold: assert property (
        $rose(pins.write_strobe_n) |-> $stable(pins.lower_lane_enable_n)
            && $stable(pins.upper_lane_enable_n)
    ) else $error("lane enable changed at write end");

    a_addr_at_select: assert property (
        $fell(pins.select_low_active) |=> $stable(pins.addr)
    ) else $error("address changed after select");

    a_retain_desel: assert property (
        retain_ok |-> pins.select_low_active && !pins.select_high_active
    ) else $error("retention while selected");

    a_recover_wait: assert property (
        $fell(retain_ok) |-> !req_ready [*2]
    ) else $error("request accepted too soon after retention");

    a_read_done: assert property (
        $fell(pins.output_strobe_n) |-> ##[2:4] rd_valid
    ) else $error("read did not complete in time");

endmodule

// ===== tb/sram_dev_model.sv
// Behavioural model of the asynchronous byte-lane static RAM
`timescale 1ns/100ps
module sram_dev_model (
    // Pins from the host
    input  wire sram_host_pkg::pins_s        pins,
    // Level the device puts on the data bus
    output logic [sram_host_pkg::DATA_W-1:0] dev_dq
);
    import sram_host_pkg::*;

    // ======================================================================
    // Storage and decode
    logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
    logic              sel;
    logic              wr_act;
    logic [1:0]        lane;
    logic [1:0]        en;
    logic [1:0]        en_d;
    // Known start values: the first reset edge looks like a write end
    logic [1:0]        wl = 2'b00;
    logic [ADDR_W-1:0] wa = 18'h00000;
    logic [DATA_W-1:0] wd = 16'h0000;
    logic [DATA_W-1:0] t;
    logic [DATA_W-1:0] rdat;
    logic [DATA_W-1:0] last = 16'h5aa5;
    int                wcount = 0;

    assign sel  = !pins.select_low_active && pins.select_high_active;
    assign lane = {!pins.upper_lane_enable_n, !pins.lower_lane_enable_n};
    assign wr_act = sel && !pins.write_strobe_n && (lane != 2'b00);
    always @* if (wr_act) begin
        wl = lane;
        wa = pins.addr;
        wd = pins.dq_out;
    end

    // ======================================================================
    // Write commit
    // ends at first inactive signal
    always @(negedge wr_act) begin
        t = mem.exists(wa) ? mem[wa] : 16'h0000;
        if (wl[0]) t[7:0] = wd[7:0];
        if (wl[1]) t[15:8] = wd[15:8];
        mem[wa] = t;
        wcount++;
    end

    // ======================================================================
    // Read drive
    // old word held briefly
    always @(pins.addr or wcount)
        rdat <= #10 (mem.exists(pins.addr) ? mem[pins.addr] : 16'h0000);
    assign en = (sel && pins.write_strobe_n && !pins.output_strobe_n) ?
                lane : 2'b00;
    always @(en) en_d <= #22 en;
    // Released lanes show the inverse so a stale value never passes
    always @* begin
        if (en[0] && en_d[0]) last[7:0] = rdat[7:0];
        if (en[1] && en_d[1]) last[15:8] = rdat[15:8];
    end
    assign dev_dq = {(en[1] && en_d[1]) ? rdat[15:8] : ~last[15:8],
                     (en[0] && en_d[0]) ? rdat[7:0] : ~last[7:0]};
endmodule

// ===== tb/sram_host_tb.sv
// Self-checking bench for the asynchronous SRAM host controller
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
    miscompares++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module sram_host_tb;
    import sram_host_pkg::*;

    // ======================================================================
    // Signals
    logic              clk;
    logic              rst_n;
    logic              req_valid;
    logic              req_ready;
    logic              rd_valid;
    logic              retain_req;
    logic              retain_ok;
    req_s              req;
    pins_s             pins;
    logic [DATA_W-1:0] rd_data;
    logic [DATA_W-1:0] dq_in;
    logic [DATA_W-1:0] dev_dq;
    int                miscompares = 0;
    int                tests_run = 0;
    int                exp_mem [int];
    int                addrs[$];
    int                n;
    int                a;
    logic [2:0]        flags;

    sram_host u_sram_host (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .rd_valid(rd_valid),
        .rd_data(rd_data), .retain_req(retain_req), .retain_ok(retain_ok),
        .pins(pins), .dq_in(dq_in));
    sram_dev_model u_sram_dev_model (.pins(pins), .dev_dq(dev_dq));
    assign dq_in = pins.dq_oe ? pins.dq_out : dev_dq;

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ======================================================================
    // Closing and bus tasks
    task automatic end_sim();
        $display("Compares %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic do_req(input logic wr, input int a, input int d,
                          input logic [1:0] ln);
        int k;
        int e;
        logic seen;
        logic clash;
        logic [DATA_W-1:0] m;
        k = 0;
        seen = 1'b0;
        clash = 1'b0;
        m = {{8{ln[1]}}, {8{ln[0]}}};
        e = exp_mem.exists(a) ? exp_mem[a] : 0;
        while (req_ready !== 1'b1 && k < 20) begin @(posedge clk); #1; k++; end
        req_valid = 1'b1;
        req = '{wr, a[ADDR_W-1:0], d[DATA_W-1:0], ln};
        @(posedge clk); #1;
        req_valid = 1'b0;
        k = 0;
        while ((wr ? req_ready : rd_valid) !== 1'b1 && k < 20) begin
            if (!pins.write_strobe_n && !pins.select_low_active &&
                pins.select_high_active && pins.dq_oe &&
                pins.addr === a[ADDR_W-1:0] && pins.dq_out === d[15:0] &&
                {!pins.upper_lane_enable_n, !pins.lower_lane_enable_n} === ln)
                seen = 1'b1;
            if (!pins.output_strobe_n && pins.dq_oe) clash = 1'b1;
            @(posedge clk); #1; k++;
        end
        `CHK(k < 8, 1'b1) // answer comes in bounded time
        `CHK(clash, 1'b0) // no host drive while reading
        if (wr) begin
            `CHK(seen, 1'b1) // full write window
            if (ln[0]) e = (e & 'hff00) | (d & 'h00ff);
            if (ln[1]) e = (e & 'h00ff) | (d & 'hff00);
            exp_mem[a] = e;
        end else begin
            `CHK(rd_data & m, 16'(e) & m) // lane data
        end
    endtask

    // ======================================================================
    // Main sequence
    initial begin
        rst_n = 1'b0;
        req_valid = 1'b0;
        retain_req = 1'b0;
        req = '0;
        void'($urandom(18777));
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        `CHK({req_ready, pins.write_strobe_n, pins.dq_oe}, 3'b110)
        addrs = '{0, 'h3ffff};
        repeat (6) addrs.push_back($urandom & 'h3ffff);
        foreach (addrs[i]) do_req(1'b1, addrs[i], $urandom, 2'b11);
        // Mixed lane codes keep the partial-write paths busy
        repeat (40) begin
            a = addrs[$urandom % 8];
            do_req(1'($urandom), a, $urandom, 2'(1 + $urandom % 3));
        end
        retain_req = 1'b1;
        n = 0;
        while (retain_ok !== 1'b1 && n < 10) begin @(posedge clk); #1; n++; end
        flags = {retain_ok, pins.select_low_active, pins.select_high_active};
        `CHK(flags, 3'b110)
        req_valid = 1'b1;
        req = '{1'b1, addrs[2][ADDR_W-1:0], 16'h1234, 2'b11};
        repeat (3) @(posedge clk);
        #1 `CHK(req_ready, 1'b0) // request refused while retained
        req_valid = 1'b0;
        retain_req = 1'b0;
        n = 0;
        while (req_ready !== 1'b1 && n < 10) begin @(posedge clk); #1; n++; end
        `CHK(n >= 2, 1'b1) // recovery before next access
        foreach (addrs[i]) do_req(1'b0, addrs[i], 0, 2'b11);
        end_sim();
    end

    initial begin
        #(50 * 20000);
        miscompares++;
        end_sim();
    end
endmodule
